// ===== hdl/spmc_params.svh
`ifndef SPMC_PARAMS_SVH
`define SPMC_PARAMS_SVH
// register indices on the cpu port
`define SPMC_IDX_CTRL 2'h0
`define SPMC_IDX_STAT 2'h1
`define SPMC_IDX_DATA 2'h2
// control register fields
`define SPMC_C_RXIE 7
`define SPMC_C_MSEL 6
`define SPMC_C_CPOL 5
`define SPMC_C_PHASE 4
`define SPMC_C_WOR 3
`define SPMC_C_ON 2
`define SPMC_C_TXIE 1
`define SPMC_CTRL_RST 8'h50
`define SPMC_CTRL_WMASK 8'hfe
// status and control register fields
`define SPMC_S_RXF 7
`define SPMC_S_ERROR_IRQ_ON 6
`define SPMC_S_LOST 5
`define SPMC_S_CONF 4
`define SPMC_S_TXE 3
`define SPMC_S_FDET 2
`define SPMC_S_RATE_HI 1
`define SPMC_S_RATE_LO 0
// master baud divisors, in mclk cycles per serial clock half period
`define SPMC_BD0 8'd2
`define SPMC_BD1 8'd8
`define SPMC_BD2 8'd32
`define SPMC_BD3 8'd128
// eight serial clock cycles make sixteen edges
`define SPMC_LAST_EDGE 5'd15
// remote master timing
`define SPMC_CLK_NS 10
`define SPMC_HOST_HALF_NS 80
`endif

// ===== hdl/spmc_pkg.sv
package spmc_pkg;
  typedef enum logic [1:0] {
    spmc_idle  = 2'b00,
    spmc_setup = 2'b01,
    spmc_run   = 2'b10,
    spmc_hold  = 2'b11
  } spmc_state_t;
  typedef logic [7:0] spmc_byte_t;
endpackage

// ===== hdl/spmc_link_if.sv
`timescale 1ns/1ns
interface spmc_link_if;
  logic dev_sck_o, dev_sck_oe_n, dev_mosi_o, dev_mosi_oe_n;
  logic dev_miso_o, dev_miso_oe_n, dev_ss_o, dev_ss_oe_n;
  logic host_sck_o, host_sck_oe_n, host_mosi_o, host_mosi_oe_n;
  logic host_ss_o, host_ss_oe_n;
  logic sck, mosi, miso, ss_n;
  // wire levels from the enables; an undriven line floats high on its pullup
  assign sck = !dev_sck_oe_n ? dev_sck_o : (!host_sck_oe_n ? host_sck_o : 1'b1);
  assign mosi = !dev_mosi_oe_n ? dev_mosi_o : (!host_mosi_oe_n ? host_mosi_o : 1'b1);
  assign miso = !dev_miso_oe_n ? dev_miso_o : 1'b1;
  assign ss_n = !dev_ss_oe_n ? dev_ss_o : (!host_ss_oe_n ? host_ss_o : 1'b1);
  modport dev (
    input sck, mosi, miso, ss_n,
    output dev_sck_o, dev_sck_oe_n, dev_mosi_o, dev_mosi_oe_n,
    output dev_miso_o, dev_miso_oe_n, dev_ss_o, dev_ss_oe_n
  );
  modport host (
    input sck, mosi, miso, ss_n,
    output host_sck_o, host_sck_oe_n, host_mosi_o, host_mosi_oe_n,
    output host_ss_o, host_ss_oe_n
  );
endinterface

// ===== hdl/spmc_sync.sv
`timescale 1ns/1ns
module spmc_sync #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q, s2_q, s3_q, lvl_q, lvl_d;
      // the first stage feeds only the second; stages two and three vote
      always_comb begin
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
      end
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          lvl_q <= 1'b1;
        end else begin
          s1_q <= raw[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          lvl_q <= lvl_d;
        end
      end
      assign level[i] = lvl_q;
    end
  endgenerate
endmodule

// ===== hdl/spmc_dev.sv
// Overview of operation
// - of the two resets, only system reset clears control bits and flags
// - master fault with detect on clears module_on
// - wait keeps running, blocks cpu, irq wakes
// - stop freezes core registers, kept; synchroniser, pad, irq and select readback flops still update
// - reset leaving stop aborts and resets all
// - protected break: accesses leave flags alone
// - permitted break: clears stick after break
// - protected break: data write fully ignored
// - wired-or select makes mosi open drain
// - miso driven only by selected slave
// - enabled module owns miso, mosi, sck direction
// - master drives clock; eight cycles per byte
// - phase 0 master toggles select per byte
// - slave always uses select as input
// - deselected slave floats miso, ignores clocks
// - master select pin per fault detect
// - module off leaves select as port pin
// - select level readable when port input
// - software disables module before idle wait
// - software sets error_irq_on for wait wake
// - module off: abort, clear, tx_empty set
// - master fault: off, tx_empty, pins released
`timescale 1ns/1ns
`include "spmc_params.svh"
module spmc_dev
  import spmc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [1:0] cpu_sel,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic irq_req,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic break_active,
  input wire logic break_clear_allow,
  input wire logic [3:0] port_ddr,
  input wire logic [3:0] port_dout,
  output logic port_ss_level,
  spmc_link_if.dev lnk
);
  // pin order in port vectors: 0 miso, 1 mosi, 2 sck, 3 select
  logic [3:0] pin_l;
  logic ss_l, sck_l, in_bit;
  logic [7:0] ctrl_q, ctrl_d, txd_q, txd_d, rxd_q, rxd_d, sr_q, sr_d, div_q, div_d, bd;
  logic [7:0] rdata_q, rdata_d, stat_v;
  logic [1:0] rate_q, rate_d;
  logic error_irq_on_q, error_irq_on_d, fdet_q, fdet_d;
  logic rxf_q, rxf_d, lost_q, lost_d, conf_q, conf_d, txe_q, txe_d;
  logic arm_rx_q, arm_rx_d, arm_lost_q, arm_lost_d, arm_conf_q, arm_conf_d;
  logic bit_q, bit_d, sck_q, sck_d, ss_prev_q, sck_prev_q, irq_q, irq_d, pss_q, pss_d;
  logic [4:0] edge_q, edge_d;
  spmc_state_t st_q, st_d;
  logic [3:0] po_q, po_d, poe_n_q, poe_n_d;
  logic on, mstr, clock_phase_select, cpol, acc, protect, tick, m_edge, s_edge, ev, sel, done;
  logic mfault, sfault;

  // every pin passes four flops before any decision
  spmc_sync #(.W(4)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .raw({lnk.ss_n, lnk.sck, lnk.mosi, lnk.miso}),
    .level(pin_l)
  );

  assign ss_l = pin_l[3];
  assign sck_l = pin_l[2];
  assign on = ctrl_q[`SPMC_C_ON];
  assign mstr = ctrl_q[`SPMC_C_MSEL];
  assign clock_phase_select = ctrl_q[`SPMC_C_PHASE];
  assign cpol = ctrl_q[`SPMC_C_CPOL];
  assign in_bit = mstr ? pin_l[0] : pin_l[1];
  // cpu cannot reach the registers in wait or stop
  assign acc = !wait_mode && !stop_mode;
  assign protect = break_active && !break_clear_allow;
  assign sel = on && !mstr && !ss_l;
  assign tick = div_q == bd - 8'd1;
  assign m_edge = on && mstr && (st_q == spmc_run) && tick;
  // a deselected slave sees no clock edges at all
  assign s_edge = sel && (sck_l != sck_prev_q) && (st_q == spmc_run || clock_phase_select);
  assign ev = m_edge || s_edge;
  assign done = ev && (edge_q == `SPMC_LAST_EDGE);
  assign mfault = on && mstr && fdet_q && !ss_l;
  assign sfault = on && !mstr && fdet_q && (st_q == spmc_run) && ss_l && !ss_prev_q;
  assign stat_v = {rxf_q, error_irq_on_q, lost_q, conf_q, txe_q, fdet_q, rate_q};

  // baud divisor for the master clock
  always_comb begin
    case (rate_q)
      2'b00: bd = `SPMC_BD0;
      2'b01: bd = `SPMC_BD1;
      2'b10: bd = `SPMC_BD2;
      default: bd = `SPMC_BD3;
    endcase
  end

  // next state; stop holds every register updated here at its value
  always_comb begin
    ctrl_d = ctrl_q;
    error_irq_on_d = error_irq_on_q;
    fdet_d = fdet_q;
    rate_d = rate_q;
    rxf_d = rxf_q;
    lost_d = lost_q;
    conf_d = conf_q;
    txe_d = txe_q;
    arm_rx_d = arm_rx_q;
    arm_lost_d = arm_lost_q;
    arm_conf_d = arm_conf_q;
    txd_d = txd_q;
    rxd_d = rxd_q;
    sr_d = sr_q;
    div_d = div_q;
    edge_d = edge_q;
    st_d = st_q;
    bit_d = bit_q;
    sck_d = sck_q;
    rdata_d = rdata_q;
    if (!stop_mode) begin
      // cpu writes; clears come first so that a hardware set wins
      if (acc && cpu_wr) begin
        case (cpu_sel)
          `SPMC_IDX_CTRL: begin
            ctrl_d = cpu_wdata & `SPMC_CTRL_WMASK;
            if (arm_conf_q && !protect) begin
              conf_d = 1'b0;
              arm_conf_d = 1'b0;
            end
          end
          `SPMC_IDX_STAT: begin
            error_irq_on_d = cpu_wdata[`SPMC_S_ERROR_IRQ_ON];
            fdet_d = cpu_wdata[`SPMC_S_FDET];
            rate_d = cpu_wdata[`SPMC_S_RATE_HI:`SPMC_S_RATE_LO];
          end
          `SPMC_IDX_DATA: begin
            if (!protect) begin
              txd_d = cpu_wdata;
              txe_d = 1'b0;
            end
          end
          default: ;
        endcase
      end
      // cpu reads; a protected break neither arms nor completes a clear
      if (acc && cpu_rd) begin
        case (cpu_sel)
          `SPMC_IDX_CTRL: rdata_d = ctrl_q;
          `SPMC_IDX_STAT: begin
            rdata_d = stat_v;
            if (!protect) begin
              arm_rx_d = rxf_q;
              arm_lost_d = lost_q;
              arm_conf_d = conf_q;
            end
          end
          `SPMC_IDX_DATA: begin
            rdata_d = rxd_q;
            if (!protect) begin
              if (arm_rx_q) rxf_d = 1'b0;
              if (arm_lost_q) lost_d = 1'b0;
              arm_rx_d = 1'b0;
              arm_lost_d = 1'b0;
            end
          end
          default: rdata_d = 8'h00;
        endcase
      end
      // load the shifter; a master starts its exchange here
      if (on && st_q == spmc_idle && !txe_q) begin
        sr_d = txd_q;
        bit_d = txd_q[7];
        txe_d = 1'b1;
        if (mstr) begin
          st_d = spmc_run;
          div_d = 8'h00;
          edge_d = 5'd0;
        end
      end
      if (on && mstr && st_q == spmc_run) begin
        div_d = tick ? 8'h00 : div_q + 8'd1;
        if (tick) sck_d = !sck_q; // master makes the serial clock
      end
      // phase 0 slave starts on falling select, phase 1 on first edge
      if (sel && st_q == spmc_idle && !clock_phase_select && ss_prev_q) st_d = spmc_run;
      if (s_edge && st_q == spmc_idle) st_d = spmc_run;
      // sixteen edges, one bit out and one in per serial cycle
      if (ev) begin
        if (!edge_q[0]) begin
          if (clock_phase_select) bit_d = sr_q[7];
          else sr_d = {sr_q[6:0], in_bit};
        end else begin
          if (clock_phase_select) sr_d = {sr_q[6:0], in_bit};
          else bit_d = sr_q[7];
        end
        edge_d = edge_q + 5'd1;
      end
      if (done) begin
        st_d = spmc_idle;
        edge_d = 5'd0;
        if (rxf_d) lost_d = 1'b1; // byte already held stays, new one is lost
        else begin
          rxd_d = sr_d;
          rxf_d = 1'b1;
        end
      end
      // faults set the flag; a master fault switches the module off
      if (sfault) conf_d = 1'b1;
      if (mfault) begin
        conf_d = 1'b1;
        ctrl_d[`SPMC_C_ON] = 1'b0;
      end
      // partial reset while off keeps control bits and flags other than tx_empty, which it sets
      if (!ctrl_d[`SPMC_C_ON]) begin
        txe_d = 1'b1;
        st_d = spmc_idle;
        sr_d = 8'h00;
        edge_d = 5'd0;
        div_d = 8'h00;
        sck_d = ctrl_d[`SPMC_C_CPOL];
      end else if (st_d == spmc_idle) begin
        sck_d = ctrl_d[`SPMC_C_CPOL];
      end
    end
  end

  // pad drive and enables, request line and select readback
  always_comb begin
    po_d = port_dout;
    poe_n_d = ~port_ddr; // off: port direction register
    if (on) begin
      // enabled module owns these three pads
      if (mstr) begin
        poe_n_d[2:0] = {1'b0, 1'b0, 1'b1};
        po_d[2] = sck_q;
        po_d[1] = ctrl_q[`SPMC_C_WOR] ? 1'b0 : bit_q;
        if (ctrl_q[`SPMC_C_WOR]) poe_n_d[1] = bit_q; // open drain
      end else begin
        poe_n_d[2:0] = {1'b1, 1'b1, ss_l};
        po_d[0] = bit_q;
      end
      if (!mstr || fdet_q) poe_n_d[3] = 1'b1; // select as input
    end
    // enabled request also serves as wake from wait
    irq_d = (ctrl_q[`SPMC_C_RXIE] && rxf_q) || (ctrl_q[`SPMC_C_TXIE] && on && txe_q)
      || (error_irq_on_q && (lost_q || conf_q));
    pss_d = port_ddr[3] ? port_dout[3] : ss_l;
  end

  // system reset returns everything to defaults
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_q <= `SPMC_CTRL_RST;
      error_irq_on_q <= 1'b0;
      fdet_q <= 1'b0;
      rate_q <= 2'b00;
      rxf_q <= 1'b0;
      lost_q <= 1'b0;
      conf_q <= 1'b0;
      txe_q <= 1'b1;
      arm_rx_q <= 1'b0;
      arm_lost_q <= 1'b0;
      arm_conf_q <= 1'b0;
      txd_q <= 8'h00;
      rxd_q <= 8'h00;
      sr_q <= 8'h00;
      div_q <= 8'h00;
      edge_q <= 5'd0;
      st_q <= spmc_idle;
      bit_q <= 1'b0;
      sck_q <= 1'b0;
      rdata_q <= 8'h00;
      ss_prev_q <= 1'b1;
      sck_prev_q <= 1'b1;
      irq_q <= 1'b0;
      pss_q <= 1'b1;
      po_q <= 4'hf;
      poe_n_q <= 4'hf;
    end else begin
      ctrl_q <= ctrl_d;
      error_irq_on_q <= error_irq_on_d;
      fdet_q <= fdet_d;
      rate_q <= rate_d;
      rxf_q <= rxf_d;
      lost_q <= lost_d;
      conf_q <= conf_d;
      txe_q <= txe_d;
      arm_rx_q <= arm_rx_d;
      arm_lost_q <= arm_lost_d;
      arm_conf_q <= arm_conf_d;
      txd_q <= txd_d;
      rxd_q <= rxd_d;
      sr_q <= sr_d;
      div_q <= div_d;
      edge_q <= edge_d;
      st_q <= st_d;
      bit_q <= bit_d;
      sck_q <= sck_d;
      rdata_q <= rdata_d;
      ss_prev_q <= stop_mode ? ss_prev_q : ss_l;
      sck_prev_q <= stop_mode ? sck_prev_q : sck_l;
      irq_q <= irq_d;
      pss_q <= pss_d;
      po_q <= po_d;
      poe_n_q <= poe_n_d;
    end
  end

  assign cpu_rdata = rdata_q;
  assign irq_req = irq_q;
  assign port_ss_level = pss_q;
  assign lnk.dev_miso_o = po_q[0];
  assign lnk.dev_mosi_o = po_q[1];
  assign lnk.dev_sck_o = po_q[2];
  assign lnk.dev_ss_o = po_q[3];
  assign lnk.dev_miso_oe_n = poe_n_q[0];
  assign lnk.dev_mosi_oe_n = poe_n_q[1];
  assign lnk.dev_sck_oe_n = poe_n_q[2];
  assign lnk.dev_ss_oe_n = poe_n_q[3];
endmodule

// ===== hdl/spmc_host.sv
`timescale 1ns/1ns
`include "spmc_params.svh"
module spmc_host
  import spmc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  input wire logic cpol,
  input wire logic clock_phase_select,
  input wire logic keep_select,
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte,
  spmc_link_if.host lnk
);
  localparam logic [7:0] HALF = 8'(`SPMC_HOST_HALF_NS / `SPMC_CLK_NS);
  spmc_state_t st_q, st_d;
  logic [7:0] div_q, div_d, sr_q, sr_d, rx_q, rx_d;
  logic [4:0] edge_q, edge_d;
  logic sck_q, sck_d, bit_q, bit_d, ss_q, ss_d, busy_q, busy_d, done_q, done_d, tick;

  assign tick = div_q == HALF - 8'd1;

  // remote master: select, divided clock and sixteen edges per byte
  always_comb begin
    st_d = st_q;
    div_d = tick ? 8'h00 : div_q + 8'd1;
    sr_d = sr_q;
    rx_d = rx_q;
    edge_d = edge_q;
    sck_d = sck_q;
    bit_d = bit_q;
    ss_d = ss_q;
    done_d = 1'b0;
    case (st_q)
      spmc_idle: begin
        div_d = 8'h00;
        sck_d = cpol;
        if (start) begin
          sr_d = tx_byte;
          bit_d = tx_byte[7];
          ss_d = 1'b0;
          edge_d = 5'd0;
          st_d = spmc_setup;
        end
      end
      spmc_setup: if (tick) st_d = spmc_run;
      spmc_run: begin
        if (tick) begin
          sck_d = !sck_q;
          if (!edge_q[0]) begin
            if (clock_phase_select) bit_d = sr_q[7];
            else sr_d = {sr_q[6:0], lnk.miso};
          end else begin
            if (clock_phase_select) sr_d = {sr_q[6:0], lnk.miso};
            else bit_d = sr_q[7];
          end
          edge_d = edge_q + 5'd1;
          if (edge_q == `SPMC_LAST_EDGE) st_d = spmc_hold;
        end
      end
      spmc_hold: begin
        if (tick) begin
          // phase 0 needs a select pulse between bytes
          ss_d = clock_phase_select && keep_select ? 1'b0 : 1'b1;
          rx_d = sr_q;
          done_d = 1'b1;
          st_d = spmc_idle;
        end
      end
      default: st_d = spmc_idle;
    endcase
    busy_d = st_d != spmc_idle;
  end

  // registers of the remote master
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= spmc_idle;
      div_q <= 8'h00;
      sr_q <= 8'h00;
      rx_q <= 8'h00;
      edge_q <= 5'd0;
      sck_q <= 1'b0;
      bit_q <= 1'b1;
      ss_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      sr_q <= sr_d;
      rx_q <= rx_d;
      edge_q <= edge_d;
      sck_q <= sck_d;
      bit_q <= bit_d;
      ss_q <= ss_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign rx_byte = rx_q;
  assign lnk.host_sck_o = sck_q;
  assign lnk.host_sck_oe_n = 1'b0;
  assign lnk.host_mosi_o = bit_q;
  assign lnk.host_mosi_oe_n = !busy_q; // idle host lets mosi go, so a device master can own it
  assign lnk.host_ss_o = ss_q;
  assign lnk.host_ss_oe_n = 1'b0;
endmodule

// ===== test/spmc_chk.sv
`timescale 1ns/1ns
module spmc_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ss_n,
  input wire logic dev_sck_o,
  input wire logic dev_sck_oe_n,
  input wire logic dev_mosi_oe_n,
  input wire logic dev_miso_oe_n,
  input wire logic host_sck_o,
  input wire logic host_ss_o
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // a long deselect leaves miso floating, after the synchroniser latency
  miso_float_a: assert property (ss_n [*8] |-> dev_miso_oe_n)
    else $error("miso driven while deselected");
  master_no_miso_a: assert property (!dev_sck_oe_n |-> dev_miso_oe_n)
    else $error("clock owner also drives miso");
  // select must pass four synchroniser flops and the pad flop before the pad can react
  sync_delay_a: assert property ($fell(ss_n) |-> dev_miso_oe_n ##1 dev_miso_oe_n)
    else $error("miso reacted to raw select");
  dev_half_a: assert property (!dev_sck_oe_n && $changed(dev_sck_o) |=> $stable(dev_sck_o))
    else $error("device clock half period below two cycles");
  host_half_a: assert property ($changed(host_sck_o) |=> $stable(host_sck_o) [*7])
    else $error("remote clock half period not eight cycles");
  host_sel_a: assert property ($changed(host_sck_o) |-> !host_ss_o)
    else $error("remote clock moved while deselected");
  // mosi is only owned together with the clock pin
  pin_owner_a: assert property (!dev_mosi_oe_n |-> !dev_sck_oe_n)
    else $error("mosi driven without clock ownership");
  pins_release_a: assert property ($rose(dev_sck_oe_n) |-> dev_mosi_oe_n)
    else $error("mosi kept after clock released");

  cover property ($fell(dev_sck_oe_n));
  cover property ($fell(dev_miso_oe_n));
  cover property ($rose(host_ss_o));
endmodule

// ===== test/spmc_tb.sv
`timescale 1ns/1ns
module spmc_tb
  import spmc_pkg::*;
;
  logic mclk = 0, reset = 1;
  logic [1:0] cpu_sel = 0;
  logic cpu_wr = 0, cpu_rd = 0, irq_req, port_ss_level;
  logic [7:0] cpu_wdata = 0, cpu_rdata, tx_byte = 0, rx_byte;
  logic wait_mode = 0, stop_mode = 0, brk = 0, bca = 0;
  logic [3:0] port_ddr = 0, port_dout = 0;
  logic start = 0, clock_phase_select = 0, keep = 0, cpol = 0, busy, done, sck_q = 1;
  int fail_count = 0, n_checks = 0, n_edge = 0, wo_bad = 0, i;
  spmc_byte_t mcap = 0;

  always #5 mclk = ~mclk;

  spmc_link_if lnk();
  spmc_dev spmc_dev_i (.mclk(mclk), .reset(reset), .cpu_sel(cpu_sel), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .irq_req(irq_req),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .break_active(brk),
    .break_clear_allow(bca), .port_ddr(port_ddr), .port_dout(port_dout),
    .port_ss_level(port_ss_level), .lnk(lnk.dev));
  spmc_host spmc_host_i (.mclk(mclk), .reset(reset), .start(start), .tx_byte(tx_byte),
    .cpol(cpol), .clock_phase_select(clock_phase_select), .keep_select(keep), .busy(busy), .done(done),
    .rx_byte(rx_byte), .lnk(lnk.host));
  spmc_chk spmc_chk_i (.mclk(mclk), .reset(reset), .ss_n(lnk.ss_n),
    .dev_sck_o(lnk.dev_sck_o), .dev_sck_oe_n(lnk.dev_sck_oe_n),
    .dev_mosi_oe_n(lnk.dev_mosi_oe_n), .dev_miso_oe_n(lnk.dev_miso_oe_n),
    .host_sck_o(lnk.host_sck_o), .host_ss_o(lnk.host_ss_o));

  // wire monitor on the falling mclk edge, clear of the pad updates
  always @(negedge mclk) begin
    if (lnk.sck !== sck_q) n_edge++;
    if (sck_q && !lnk.sck) mcap = {mcap[6:0], lnk.mosi};
    if (!lnk.dev_mosi_oe_n && lnk.dev_mosi_o) wo_bad++;
    sck_q = lnk.sck;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic hang();
    fail_count++;
    $display("MISMATCH wait expected done seen timeout");
    test_done();
  endtask

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one strobe cycle; read data is registered at the closing edge
  task automatic acc(input logic [1:0] s, input logic w, input logic [7:0] d);
    tick(1);
    cpu_sel = s;
    cpu_wdata = d;
    cpu_wr = w;
    cpu_rd = !w;
    tick(1);
    cpu_wr = 0;
    cpu_rd = 0;
  endtask

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    acc(s, 1'b1, d);
  endtask

  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    acc(s, 1'b0, 8'h00);
    chk($sformatf("reg%0d", s), cpu_rdata, e);
  endtask

  // gap after done lets the slave see select high between bytes
  task automatic xfer(input logic [7:0] b, input logic ph, input logic k);
    int j;
    tick(1);
    tx_byte = b;
    clock_phase_select = ph;
    keep = k;
    start = 1;
    tick(1);
    start = 0;
    for (j = 0; j < 3000 && done !== 1'b1; j++) tick(1);
    if (j == 3000) hang();
    tick(10);
  endtask

  initial begin
    tick(4);
    reset = 0;
    rd(0, 8'h50);
    rd(1, 8'h08);
    // slave, phase 0, one byte each way
    wr(1, 8'h44);
    wr(0, 8'h04);
    wr(2, 8'ha5);
    xfer(8'h3c, 0, 0);
    chk("host rx", rx_byte, 8'ha5);
    rd(1, 8'hcc);
    rd(2, 8'h3c);
    rd(1, 8'h4c);
    // phase 1, select held low, second byte overruns
    wr(0, 8'h14);
    xfer(8'h11, 1, 1);
    xfer(8'h22, 1, 0);
    wr(0, 8'h10);
    rd(1, 8'hec);
    rd(0, 8'h10);
    chk("irq", {7'h0, irq_req}, 8'h01);
    // protected break: first step armed before it
    brk = 1;
    rd(2, 8'h11);
    chk("irq", {7'h0, irq_req}, 8'h01);
    brk = 0;
    rd(2, 8'h11);
    rd(1, 8'h4c);
    chk("irq", {7'h0, irq_req}, 8'h00);
    // accesses refused in wait, the slave keeps receiving, overflow wakes
    wr(0, 8'h14); // error_irq_on stays set so an overflow can wake
    wait_mode = 1;
    acc(2, 1'b0, 8'h00);
    chk("rdata", cpu_rdata, 8'h4c);
    xfer(8'h11, 1, 0);
    xfer(8'h22, 1, 0);
    chk("irq", {7'h0, irq_req}, 8'h01);
    wait_mode = 0;
    wr(0, 8'h10); // module off before any idle wait
    // accesses refused in stop
    stop_mode = 1;
    wr(0, 8'h00);
    stop_mode = 0;
    rd(0, 8'h10);
    // permitted break: clears stick
    wr(0, 8'h14);
    xfer(8'h11, 1, 0);
    xfer(8'h22, 1, 0);
    {brk, bca} = 2'b11;
    rd(1, 8'hec);
    rd(2, 8'h11);
    {brk, bca} = 2'b00;
    rd(1, 8'h4c);
    brk = 1;
    wr(2, 8'h77);
    rd(1, 8'h4c);
    brk = 0;
    rd(1, 8'h4c);
    // master with wired-or mosi, second rate
    wr(1, 8'h45);
    wr(0, 8'h5c);
    tick(2);
    n_edge = 0;
    wo_bad = 0;
    wr(2, 8'h96);
    for (i = 0; i < 300; i++) begin
      acc(1, 1'b0, 8'h00);
      if (cpu_rdata[7]) break;
    end
    if (i == 300) hang();
    rd(2, 8'hff);
    chk("edges", n_edge[7:0], 8'h10);
    chk("mosi", mcap, 8'h96);
    chk("drive1", wo_bad[7:0], 8'h00);
    // remote select low makes a master fault
    xfer(8'h00, 0, 0);
    rd(0, 8'h58);
    rd(1, 8'h5d);
    chk("irq", {7'h0, irq_req}, 8'h01);
    // select pin ownership per mode
    wr(1, 8'h00);
    wr(0, 8'h54);
    port_ddr = 4'h8;
    tick(8);
    chk("ss", {7'h0, lnk.ss_n}, 8'h00);
    rd(0, 8'h54);
    rd(1, 8'h08);
    wr(0, 8'h04);
    tick(8);
    chk("ss", {7'h0, lnk.ss_n}, 8'h01);
    wr(0, 8'h00);
    tick(8);
    chk("ss", {7'h0, lnk.ss_n}, 8'h00);
    chk("ss level", {7'h0, port_ss_level}, 8'h00);
    port_ddr = 4'h0;
    tick(8);
    chk("ss level", {7'h0, port_ss_level}, 8'h01);
    // leave stop through reset
    stop_mode = 1;
    tick(2);
    reset = 1;
    stop_mode = 0;
    tick(2);
    reset = 0;
    rd(0, 8'h50);
    rd(1, 8'h08);
    test_done();
  end
endmodule
